// File: adc_cal_pkg.sv
// shared constants and types for the converter calibration/sync control
package adc_cal_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_OFFSET = 8'h08;
    localparam logic [7:0] ADDR_GAIN   = 8'h0c;
    localparam logic [7:0] ADDR_RESULT = 8'h10;

    // control register field positions
    localparam int CTRL_STANDBY  = 0;
    localparam int CTRL_CAL      = 1;
    localparam int CTRL_POLARITY = 2;
    localparam int CTRL_PIN_FUNC = 3;
    localparam int CTRL_TEST     = 9;

    // status register field positions
    localparam int STAT_BUSY     = 0;
    localparam int STAT_HOLD     = 1;
    localparam int STAT_SERIAL   = 2;
    localparam int STAT_CORR_OK  = 3;
    localparam int STAT_MISMATCH = 4;
    localparam int STAT_VALID    = 5;
    localparam int STAT_STANDBY  = 6;
    localparam int STAT_STATE_LO = 8;

    // pin vector positions for the input synchronisers
    localparam int PIN_SERIAL = 0;
    localparam int PIN_POL    = 1;
    localparam int PIN_LOW_POWER_HOLD   = 2;
    localparam int PIN_CAL    = 3;
    localparam int PIN_ALIGN  = 4;
    localparam int PIN_SHARED = 5;
    localparam int PIN_COUNT  = 6;

    // timing counts in master clock cycles
    localparam int WORD_CYCLES      = 32;
    localparam int SYNC_HOLD_CYCLES = 2080;
    localparam int CAL_MAX_UNI      = 6720;
    localparam int CAL_MAX_BI       = 9024;
    localparam int CAL_AVG_WORDS    = 8;
    localparam int STRAP_WAIT       = 4;
    localparam logic [11:0] HOLD_COUNT = 12'(SYNC_HOLD_CYCLES);
    // settle words per phase: three settles plus two averages fit
    localparam logic [7:0] SETTLE_UNI = 8'(
        (CAL_MAX_UNI / WORD_CYCLES - 2 * CAL_AVG_WORDS - 2) / 3);
    localparam logic [7:0] SETTLE_BI = 8'(
        (CAL_MAX_BI / WORD_CYCLES - 2 * CAL_AVG_WORDS - 2) / 3);

    // gain correction format and reset values
    localparam int          GAIN_FRAC   = 14;
    localparam logic [15:0] GAIN_UNITY  = 16'h4000;
    localparam logic [15:0] TARGET_UNI  = 16'hffff;
    localparam logic [15:0] TARGET_BI   = 16'h7fff;
    localparam logic [4:0]  DIV_STEPS   = 5'h1e;

    // modulator input routing
    typedef enum logic [1:0] {
        MOD_PINS, MOD_SHORTED, MOD_REFERENCE
    } mod_sel_t;

    // calibration sequencer states
    typedef enum logic [2:0] {
        CAL_IDLE, CAL_OFS_SETTLE, CAL_OFS_AVG, CAL_GAIN_SETTLE,
        CAL_GAIN_AVG, CAL_GAIN_DIV, CAL_FINAL_SETTLE
    } cal_state_t;

    // apb request from master
    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    // apb answer to master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

endpackage : adc_cal_pkg

// File: adc_calibration_sync_control.sv
// calibration sequencer, sync control and output coding of the converter
//
// Summary of operation
// - bipolar results coded as two's complement
// - unipolar results coded as straight binary
// - offset: short inputs, settle, average eight
// - gain: reference input, settle, average eight
// - output equals (raw minus offset) times gain
// - reconnect pins, hold data until settled
// - sequence runs alone; host only starts it
// - corrections tied to polarity at start
// - calibration within 6720 or 9024 cycles
// - ready held high parallel, low serial
// - align rising edge aborts calibration, syncs
// - standby aborts a running calibration
// - corrections kept; change only at completion
// - serial strap low clears corrections
// - calibration leaves word phase untouched
// - one output word every 32 cycles
// - align resets filter, holds ready 2080 cycles
// - sync leaves corrections untouched
// - align sampled on clock, one-cycle uncertainty
// - pin function bit: 0 valid out, 1 align
// - calibrate bit starts, cleared at end
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module adc_calibration_sync_control (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // register bus
    input  wire adc_cal_pkg::apb_req_t apb_req,
    output adc_cal_pkg::apb_rsp_t     apb_rsp,
    // mode pins, serial mode
    input  wire logic                 serial_mode_pin,
    input  wire logic                 polarity_select,
    input  wire logic                 low_power_pin,
    input  wire logic                 calibrate_pin,
    input  wire logic                 align_pin,
    // shared valid/align pin
    input  wire logic                 shared_valid_align_pin_i,
    output logic                      shared_valid_align_pin_o,
    output logic                      shared_valid_align_pin_oe,
    // filter and modulator side
    input  wire logic [15:0]          raw_word,
    input  wire logic                 filter_overrange,
    output logic                      filter_reset,
    output adc_cal_pkg::mod_sel_t     mod_input_sel,
    output logic                      low_power_hold,
    // results
    output logic [15:0]               result_word,
    output logic                      word_ready_flag,
    output logic                      result_valid_out
);
    import adc_cal_pkg::*;

    // whole state of the block
    typedef struct packed {
        logic [PIN_COUNT-1:0] s1;      // first sync stage
        logic [PIN_COUNT-1:0] s2;      // second sync stage
        logic [PIN_COUNT-1:0] s3;      // third sync stage
        logic [PIN_COUNT-1:0] lvl;     // accepted pin levels
        logic [2:0]   strap_cnt;       // wait before strap capture
        logic         strap_done;      // strap taken
        logic         standby_bit;     // control fields
        logic         calibrate_bit;
        logic         polarity_bit;
        logic         pin_function_bit;
        logic         test_bit;
        logic         standby_prev;    // standby of last cycle
        logic [4:0]   phase;           // word phase
        logic [11:0]  hold_cnt;        // ready hold-off
        cal_state_t   cal_state;       // sequencer
        mod_sel_t     mod_sel;         // modulator routing
        logic [7:0]   word_cnt;        // words in phase
        logic         cal_bipolar;     // polarity at start
        logic signed [20:0] acc;       // calibration averaging accumulator
        logic signed [17:0] new_offset; // offset under test
        logic signed [17:0] div_den;   // measured gain span
        logic [18:0]  div_rem;         // divider remainder
        logic [29:0]  div_num;         // divider numerator
        logic [29:0]  div_q;           // divider quotient
        logic [4:0]   div_cnt;         // divider steps
        logic signed [17:0] offset;    // offset correction
        logic [15:0]  gain;            // gain correction
        logic         corr_bipolar;    // polarity of corrections
        logic         corr_valid;      // corrections loaded
        logic [15:0]  result;          // output word
        logic         result_valid;    // not clipped
        logic         ready_flag;      // ready indicator
        logic         filt_rst;        // filter reset pulse
        logic [31:0]  rdata;           // read data
    } state_t;

    state_t r;       // registered state
    state_t n;       // next state

    // next-state logic
    always_comb begin
        logic [PIN_COUNT-1:0] pins;
        logic [PIN_COUNT-1:0] rise;
        logic              serial;
        logic              standby;
        logic              bipolar;
        logic              align_rise;
        logic              tick;
        logic              busy;
        logic              setup;
        logic              wr_ctrl;
        logic [7:0]        settle;
        logic signed [17:0] raw_ext;
        logic signed [18:0] diff;
        logic signed [36:0] prod;
        logic signed [22:0] scaled;
        logic signed [20:0] sum;
        logic [18:0]       rem_sh;
        pins = '0;
        rise = '0;
        serial = 1'b0;
        standby = 1'b0;
        bipolar = 1'b0;
        align_rise = 1'b0;
        tick = 1'b0;
        busy = 1'b0;
        setup = 1'b0;
        wr_ctrl = 1'b0;
        settle = '0;
        raw_ext = '0;
        diff = '0;
        prod = '0;
        scaled = '0;
        sum = '0;
        rem_sh = '0;
        n = r;
        n.filt_rst = 1'b0;

        // three-stage pin synchronisers
        pins[PIN_SERIAL] = serial_mode_pin;
        pins[PIN_POL]    = polarity_select;
        pins[PIN_LOW_POWER_HOLD]   = low_power_pin;
        pins[PIN_CAL]    = calibrate_pin;
        pins[PIN_ALIGN]  = align_pin;
        pins[PIN_SHARED] = shared_valid_align_pin_i;
        n.s1 = pins;
        n.s2 = r.s1;
        n.s3 = r.s2;
        // a change counts once stages two and three agree
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                n.lvl[i] = r.s3[i];
            end
        end
        rise = n.lvl & ~r.lvl;

        // effective modes: pins in serial, bits in parallel
        serial  = r.lvl[PIN_SERIAL];
        standby = serial ? r.lvl[PIN_LOW_POWER_HOLD] : r.standby_bit;
        bipolar = serial ? r.lvl[PIN_POL] : r.polarity_bit;
        // align source follows mode and pin function
        align_rise = serial ? rise[PIN_ALIGN]
                            : (r.pin_function_bit & rise[PIN_SHARED]);
        n.standby_prev = standby;

        // register bus: writes in access, read data caught at setup
        setup   = apb_req.psel & ~apb_req.penable;
        wr_ctrl = apb_req.psel & apb_req.penable & apb_req.pwrite
                  & (apb_req.paddr == ADDR_CTRL);
        if (setup) begin
            unique case (apb_req.paddr)
                ADDR_CTRL: begin
                    n.rdata = '0;
                    n.rdata[CTRL_STANDBY]  = r.standby_bit;
                    n.rdata[CTRL_CAL]      = r.calibrate_bit;
                    n.rdata[CTRL_POLARITY] = r.polarity_bit;
                    n.rdata[CTRL_PIN_FUNC] = r.pin_function_bit;
                    n.rdata[CTRL_TEST]     = r.test_bit;
                end
                ADDR_STATUS: begin
                    n.rdata = '0;
                    n.rdata[STAT_BUSY]     = (r.cal_state != CAL_IDLE);
                    n.rdata[STAT_HOLD]     = (r.hold_cnt != '0);
                    n.rdata[STAT_SERIAL]   = serial;
                    n.rdata[STAT_CORR_OK]  = r.corr_valid;
                    n.rdata[STAT_MISMATCH] = (r.corr_bipolar != bipolar);
                    n.rdata[STAT_VALID]    = r.result_valid;
                    n.rdata[STAT_STANDBY]  = standby;
                    n.rdata[STAT_STATE_LO +: 3] = r.cal_state;
                end
                ADDR_OFFSET: n.rdata = 32'(r.offset);
                ADDR_GAIN:   n.rdata = {16'h0000, r.gain};
                ADDR_RESULT: n.rdata = {16'h0000, r.result};
                default:     n.rdata = '0;
            endcase
        end
        if (wr_ctrl) begin
            n.standby_bit      = apb_req.pwdata[CTRL_STANDBY];
            n.polarity_bit     = apb_req.pwdata[CTRL_POLARITY];
            n.pin_function_bit = apb_req.pwdata[CTRL_PIN_FUNC];
            n.test_bit         = apb_req.pwdata[CTRL_TEST];
        end

        // power-up strap: serial with calibrate pin low clears
        if (!r.strap_done) begin
            n.strap_cnt = r.strap_cnt + 3'h1;
            if (r.strap_cnt == 3'(STRAP_WAIT)) begin
                n.strap_done = 1'b1;
                if (serial && !r.lvl[PIN_CAL]) begin
                    n.offset     = '0;
                    n.gain       = GAIN_UNITY;
                    n.corr_valid = 1'b1;
                end
            end
        end

        // word phase: free running, stopped in standby
        if (!standby) begin
            n.phase = r.phase + 5'h01;
        end
        tick = !standby && (r.phase == 5'(WORD_CYCLES - 1));

        // ready hold-off counts down while running
        if (!standby && r.hold_cnt != '0) begin
            n.hold_cnt = r.hold_cnt - 12'h001;
        end
        // leaving standby needs a fresh settle
        if (r.standby_prev && !standby) begin
            n.hold_cnt = HOLD_COUNT;
        end

        // sign or zero extend the filter output
        raw_ext = bipolar ? {{2{raw_word[15]}}, raw_word}
                          : {2'b00, raw_word};
        sum     = r.acc + 21'(raw_ext);
        settle  = r.cal_bipolar ? SETTLE_BI : SETTLE_UNI;

        // calibration sequencer, paced by word ticks
        unique case (r.cal_state)
            CAL_IDLE: begin
                n.mod_sel = MOD_PINS;
                if (r.calibrate_bit && !standby && r.strap_done) begin
                    n.cal_state   = CAL_OFS_SETTLE;
                    n.cal_bipolar = bipolar;
                    n.word_cnt    = '0;
                    n.mod_sel     = MOD_SHORTED;
                end
            end
            CAL_OFS_SETTLE: begin
                if (tick) begin
                    n.word_cnt = r.word_cnt + 8'h01;
                    if (r.word_cnt == settle - 8'h01) begin
                        n.cal_state = CAL_OFS_AVG;
                        n.word_cnt  = '0;
                        n.acc       = '0;
                    end
                end
            end
            CAL_OFS_AVG: begin
                if (tick) begin
                    n.acc      = sum;
                    n.word_cnt = r.word_cnt + 8'h01;
                    if (r.word_cnt == 8'(CAL_AVG_WORDS - 1)) begin
                        n.new_offset = 18'(sum >>> 3);
                        n.cal_state  = CAL_GAIN_SETTLE;
                        n.mod_sel    = MOD_REFERENCE;
                        n.word_cnt   = '0;
                    end
                end
            end
            CAL_GAIN_SETTLE: begin
                if (tick) begin
                    n.word_cnt = r.word_cnt + 8'h01;
                    if (r.word_cnt == settle - 8'h01) begin
                        n.cal_state = CAL_GAIN_AVG;
                        n.word_cnt  = '0;
                        n.acc       = '0;
                    end
                end
            end
            CAL_GAIN_AVG: begin
                if (tick) begin
                    n.acc      = sum;
                    n.word_cnt = r.word_cnt + 8'h01;
                    if (r.word_cnt == 8'(CAL_AVG_WORDS - 1)) begin
                        // span of reference over offset
                        n.div_den = 18'(sum >>> 3) - r.new_offset;
                        n.div_num = {r.cal_bipolar ? TARGET_BI
                                                   : TARGET_UNI,
                                     14'h0000};
                        n.div_rem   = '0;
                        n.div_q     = '0;
                        n.div_cnt   = '0;
                        n.cal_state = CAL_GAIN_DIV;
                        n.mod_sel   = MOD_PINS;
                    end
                end
            end
            CAL_GAIN_DIV: begin
                // restoring division, one quotient bit per cycle
                rem_sh    = {r.div_rem[17:0], r.div_num[29]};
                n.div_num = {r.div_num[28:0], 1'b0};
                if (r.div_den > 0 && rem_sh >= 19'(r.div_den)) begin
                    n.div_rem = rem_sh - 19'(r.div_den);
                    n.div_q   = {r.div_q[28:0], 1'b1};
                end else begin
                    n.div_rem = rem_sh;
                    n.div_q   = {r.div_q[28:0], 1'b0};
                end
                n.div_cnt = r.div_cnt + 5'h01;
                if (r.div_cnt == DIV_STEPS - 5'h01) begin
                    // load both corrections together
                    n.offset       = r.new_offset;
                    n.corr_bipolar = r.cal_bipolar;
                    n.corr_valid   = 1'b1;
                    if (r.div_den <= 0 || n.div_q[29:16] != '0) begin
                        n.gain = 16'hffff;
                    end else begin
                        n.gain = n.div_q[15:0];
                    end
                    n.cal_state = CAL_FINAL_SETTLE;
                    n.word_cnt  = '0;
                end
            end
            CAL_FINAL_SETTLE: begin
                // pins reconnected, wait for filter to settle
                if (tick) begin
                    n.word_cnt = r.word_cnt + 8'h01;
                    if (r.word_cnt == settle - 8'h01) begin
                        n.cal_state     = CAL_IDLE;
                        n.calibrate_bit = 1'b0;
                    end
                end
            end
            default: begin
                n.cal_state = CAL_IDLE;
                n.mod_sel   = MOD_PINS;
            end
        endcase

        // standby aborts calibration, corrections kept
        if (standby && r.cal_state != CAL_IDLE) begin
            n.cal_state     = CAL_IDLE;
            n.mod_sel       = MOD_PINS;
            n.calibrate_bit = 1'b0;
        end

        // align edge: abort, reset filter and phase, hold off
        if (align_rise) begin
            n.cal_state     = CAL_IDLE;
            n.mod_sel       = MOD_PINS;
            n.calibrate_bit = 1'b0;
            n.filt_rst      = 1'b1;
            n.phase         = '0;
            n.hold_cnt      = HOLD_COUNT;
        end

        // start requests: a set wins over the end-of-cycle clear
        if (wr_ctrl && apb_req.pwdata[CTRL_CAL]) begin
            n.calibrate_bit = 1'b1;
        end
        if (serial && rise[PIN_CAL]) begin
            n.calibrate_bit = 1'b1;
        end

        // output correction and coding on each word tick while not busy
        busy = (n.cal_state != CAL_IDLE) || (n.hold_cnt != '0)
               || standby;
        diff   = 19'(raw_ext) - 19'(r.offset);
        prod   = 37'(diff) * 37'($signed({1'b0, r.gain}));
        scaled = prod[36:GAIN_FRAC];
        if (tick && !busy) begin
            n.result_valid = !filter_overrange;
            if (bipolar) begin
                if (scaled > 23'sd32767) begin
                    n.result       = 16'h7fff;
                    n.result_valid = 1'b0;
                end else if (scaled < -23'sd32768) begin
                    n.result       = 16'h8000;
                    n.result_valid = 1'b0;
                end else begin
                    n.result = scaled[15:0];
                end
            end else begin
                if (scaled < 0) begin
                    n.result       = 16'h0000;
                    n.result_valid = 1'b0;
                end else if (scaled > 23'sd65535) begin
                    n.result       = 16'hffff;
                    n.result_valid = 1'b0;
                end else begin
                    n.result = scaled[15:0];
                end
            end
        end

        // ready indicator: held while busy, else word strobe
        if (serial) begin
            n.ready_flag = !busy && (n.phase == 5'h00);
        end else begin
            n.ready_flag = busy || (n.phase < 5'h02);
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0;
            r.gain     <= GAIN_UNITY;
            r.hold_cnt <= HOLD_COUNT;
            r.ready_flag <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // register bus answer: no wait states
    always_comb begin
        apb_rsp.prdata  = r.rdata;
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = apb_req.psel & apb_req.penable
                          & (apb_req.paddr != ADDR_CTRL)
                          & (apb_req.paddr != ADDR_STATUS)
                          & (apb_req.paddr != ADDR_OFFSET)
                          & (apb_req.paddr != ADDR_GAIN)
                          & (apb_req.paddr != ADDR_RESULT);
    end

    // pin and filter side outputs
    assign shared_valid_align_pin_o  = r.result_valid;
    assign shared_valid_align_pin_oe = !r.lvl[PIN_SERIAL]
                                       && !r.pin_function_bit;
    assign filter_reset     = r.filt_rst;
    assign mod_input_sel    = r.mod_sel;
    assign low_power_hold   = r.lvl[PIN_SERIAL] ? r.lvl[PIN_LOW_POWER_HOLD]
                                                : r.standby_bit;
    assign result_word      = r.result;
    assign word_ready_flag  = r.ready_flag;
    assign result_valid_out = r.result_valid;

endmodule : adc_calibration_sync_control

// File: cal_ctl_asserts.sv
// port checker for the calibration and sync control block
`timescale 1ns/100ps
module cal_ctl_asserts (
    // clock, reset and bus
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire adc_cal_pkg::apb_req_t apb_req,
    input wire adc_cal_pkg::apb_rsp_t apb_rsp,
    // mode pin and converter side
    input wire logic                  serial_mode_pin,
    input wire logic                  filter_reset,
    input wire adc_cal_pkg::mod_sel_t mod_input_sel,
    input wire logic                  low_power_hold,
    input wire logic                  word_ready_flag
);
    import adc_cal_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    int unsigned away; // cycles with inputs off the pins
    // count time spent away from the input pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) away <= 0;
        else away <= (mod_input_sel == MOD_PINS) ? 0 : away + 1;
    end
    cal_len_a: assert property (away < CAL_MAX_BI)
        else $error("calibration too long");
    rst_pulse_a: assert property (filter_reset |=> !filter_reset)
        else $error("filter reset not a pulse");
    align_abort_a: assert property (filter_reset |-> ##[0:1]
        mod_input_sel == MOD_PINS) else $error("align did not abort");
    low_power_hold_abort_a: assert property (low_power_hold |-> ##[0:2]
        mod_input_sel == MOD_PINS) else $error("standby did not abort");
    gain_order_a: assert property (mod_input_sel == MOD_REFERENCE
        |=> mod_input_sel != MOD_SHORTED) else $error("gain then offset");
    ofs_first_a: assert property ($changed(mod_input_sel) &&
        mod_input_sel == MOD_REFERENCE |-> $past(mod_input_sel) ==
        MOD_SHORTED) else $error("gain phase without offset phase");
    busy_ready_a: assert property (mod_input_sel != MOD_PINS &&
        !serial_mode_pin |-> word_ready_flag) else $error("ready low");
    hold_ready_a: assert property (filter_reset && !serial_mode_pin
        |=> word_ready_flag [*8]) else $error("ready low after align");
    cover property (filter_reset);
    cover property (mod_input_sel == MOD_REFERENCE);
    cover property (low_power_hold);
endmodule : cal_ctl_asserts

// File: host_filter_model.sv
// host and filter stand-in: fixed words per routing, align drive
`timescale 1ns/100ps
module host_filter_model (
    // clock and routing seen
    input  wire logic                  pclk,
    input  wire adc_cal_pkg::mod_sel_t mod_input_sel,
    // align request and shared pin drive of the design
    input  wire logic                  align_req,
    input  wire logic                  pin_oe,
    input  wire logic                  pin_o,
    // toward the design
    output logic [15:0]                raw_word,
    output logic                       filter_overrange,
    output logic                       pin_level
);
    import adc_cal_pkg::*;
    logic host_drv; // host level on the shared pin
    initial host_drv = 1'b0;
    initial raw_word = 16'h0000;
    assign filter_overrange = 1'b0;
    // design drive wins, else host
    assign pin_level = pin_oe ? pin_o : host_drv;
    // align moves between clock edges
    always @(negedge pclk) host_drv <= align_req;
    // offset -16, span 0x7fff: unity gain in bipolar
    always @(posedge pclk) begin
        case (mod_input_sel)
            MOD_SHORTED:   raw_word <= 16'hfff0;
            MOD_REFERENCE: raw_word <= 16'h7fef;
            default:       raw_word <= 16'h1000;
        endcase
    end
endmodule : host_filter_model

// File: tb_top.sv
// testbench for the calibration and sync control block
`timescale 1ns/100ps
module tb_top;
    import adc_cal_pkg::*;
    typedef struct packed {
        logic w; logic [7:0] a; logic [31:0] d; logic e;
    } row_t;
    apb_req_t    req;
    apb_rsp_t    rsp;
    mod_sel_t    msel;
    logic        pclk, presetn, align_req, oe, po, lvl, ovr, frst, wrf, e, v;
    logic [15:0] raw, rw;
    logic [31:0] r;
    int          mismatches, check_count, n, m;
    row_t rows[9] = '{'{0, 8'h00, 0, 0}, '{0, 8'h08, 0, 0},
        '{0, 8'h0c, 32'h4000, 0}, '{1, 8'h00, 32'hc, 0},
        '{0, 8'h00, 32'hc, 0}, '{1, 8'h0c, 1, 0},
        '{0, 8'h0c, 32'h4000, 0}, '{1, 8'h20, 1, 1}, '{0, 8'h20, 0, 1}};
    adc_calibration_sync_control i_dut (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .serial_mode_pin(1'b0), .polarity_select(1'b0),
        .low_power_pin(1'b0), .calibrate_pin(1'b1), .align_pin(1'b0),
        .shared_valid_align_pin_i(lvl), .shared_valid_align_pin_o(po),
        .shared_valid_align_pin_oe(oe), .raw_word(raw),
        .filter_overrange(ovr), .filter_reset(frst),
        .mod_input_sel(msel), .low_power_hold(), .result_word(rw),
        .word_ready_flag(wrf), .result_valid_out(v));
    host_filter_model i_host (.pclk(pclk), .mod_input_sel(msel),
        .align_req(align_req), .pin_oe(oe), .pin_o(po), .raw_word(raw),
        .filter_overrange(ovr), .pin_level(lvl));
    // free-running bus clock
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    // one apb transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{a, 1'b1, 1'b0, w, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do @(posedge pclk); while (rsp.pready !== 1'b1 && ++n < 50);
        if (n == 50) mismatches++;
        r = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask : apb
    task chk(input string s, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            $display("ERROR %s exp %h got %h", s, x, g);
            mismatches++;
        end
    endtask : chk
    task end_sim;
        if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // main sequence
    initial begin
        req = '0;
        align_req = 0;
        presetn = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk("pslverr", rows[i].e, e);
            if (!rows[i].w) chk("prdata", rows[i].d, r);
        end
        apb(1, ADDR_CTRL, 32'he);
        m = 0;
        do begin apb(0, ADDR_CTRL, 0); m++; end
        while (r[CTRL_CAL] !== 1'b0 && m < 3100);
        chk("cal end", 1, m < 3100);
        apb(0, ADDR_OFFSET, 0);
        chk("offset", 32'hfffffff0, r);
        apb(0, ADDR_GAIN, 0);
        chk("gain", 32'h4000, r);
        repeat (100) @(negedge pclk);
        chk("result", 16'h1010, rw);
        chk("valid", 1, v);
        apb(1, ADDR_CTRL, 32'he);
        repeat (200) @(posedge pclk);
        align_req <= 1;
        for (n = 0; n < 50 && frst !== 1'b1; n++) @(negedge pclk);
        chk("filter_reset", 1, frst);
        for (n = 0; n < 2200 && wrf !== 1'b0; n++) @(negedge pclk);
        chk("hold", 1, n >= 2076 && n <= 2082);
        for (n = 0; n < 40 && wrf !== 1'b1; n++) @(negedge pclk);
        m = 0;
        while (m < 40 && wrf !== 1'b0) begin @(negedge pclk); m++; end
        while (m < 40 && wrf !== 1'b1) begin @(negedge pclk); m++; end
        chk("word period", 32, m);
        align_req <= 0;
        apb(0, ADDR_CTRL, 0);
        chk("ctrl", 32'hc, r);
        apb(0, ADDR_OFFSET, 0);
        chk("offset", 32'hfffffff0, r);
        apb(1, ADDR_CTRL, 32'he);
        repeat (100) @(posedge pclk);
        apb(1, ADDR_CTRL, 32'hd);
        repeat (4) @(negedge pclk);
        chk("mod sel", MOD_PINS, msel);
        apb(0, ADDR_GAIN, 0);
        chk("gain", 32'h4000, r);
        end_sim;
    end
endmodule : tb_top
bind adc_calibration_sync_control cal_ctl_asserts i_chk (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .serial_mode_pin(serial_mode_pin), .filter_reset(filter_reset),
    .mod_input_sel(mod_input_sel), .low_power_hold(low_power_hold),
    .word_ready_flag(word_ready_flag));
